/* inc/fwp_pkg.sv */
// shared constants, command set and carriers of the flash write-protection block
package fwp_pkg;

  // sector array geometry
  localparam int SECTOR_BITS = 8;
  localparam int NUM_SECTORS = 256;

  // timing at the 250 MHz system clock
  localparam int CLK_MHZ = 250;
  localparam int PWD_GAP_US = 100;
  localparam int PWD_GAP_CYCLES = PWD_GAP_US * CLK_MHZ;
  localparam int PROG_CYCLES = 64;
  localparam int ERASE_CYCLES = 256;

  // register port map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_LOCK = 4'h2;
  localparam logic [3:0] REG_MODE = 4'h3;
  localparam logic [3:0] REG_SECT_SEL = 4'h4;
  localparam logic [3:0] REG_SECT_STATE = 4'h5;

  // status byte fields (also the low byte of write-registers data)
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_SIZE_LSB = 2;
  localparam int ST_FAIL_BIT = 6;
  localparam int ST_LOCK_BIT = 7;
  // configuration byte fields (second byte of write-registers data)
  localparam int CFG_FREEZE_BIT = 0;
  localparam int CFG_BOTTOM_BIT = 5;
  localparam int CFG_DATA_LSB = 8;

  // protection mode register: bits 2:1 select lock management
  localparam int MODE_SEL_LSB = 1;
  localparam logic [1:0] MODE_UNSELECTED = 2'h3;
  localparam logic [1:0] MODE_PERSISTENT = 2'h2;
  localparam logic [1:0] MODE_PASSWORD = 2'h1;
  localparam logic [1:0] MODE_ILLEGAL = 2'h0;
  localparam logic [7:0] MODE_REG_RESET = 8'hff;
  localparam logic [63:0] PASSWORD_RESET = 64'hffff_ffff_ffff_ffff;

  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_ALL = 3'h7;

  typedef enum logic [4:0] {
    CMD_WRITE_ENABLE, CMD_WRITE_DISABLE, CMD_SOFT_RESET, CMD_PAGE_WRITE,
    CMD_QUAD_PAGE_WRITE, CMD_REGION_WIPE, CMD_CHIP_WIPE, CMD_WRITE_REGS,
    CMD_OTP_BYTE_WRITE, CMD_PSB_PROGRAM, CMD_PSB_ERASE, CMD_VSB_WRITE,
    CMD_GUARD_LOCK_CLEAR, CMD_PASSWORD_UNLOCK, CMD_PASSWORD_PROGRAM,
    CMD_MODE_PROGRAM, CMD_CLEAR_STATUS
  } fwp_op_t;

  typedef struct packed {
    fwp_op_t op;
    logic [SECTOR_BITS-1:0] sector;
    logic [63:0] data;
  } fwp_cmd_t;

  typedef struct packed {
    fwp_op_t op;
    logic [SECTOR_BITS-1:0] sector;
  } fwp_array_req_t;

endpackage

/* src/fwp_guard.sv */
// write-enable latch, block and per-sector protection, lock and mode management
//
// Contract
// - write enable command sets the latch
// - latch clears on resets and listed completions
// - size field guards top fraction
// - bottom selector guards bottom fraction instead
// - sector protected if either scheme protects
// - freeze holds size bits and selector
// - freeze sticks until power-on reset
// - freeze refuses all OTP programming; here only OTP byte write fails
// - frozen size write ignored without error
// - protect pin low plus lock blocks registers
// - either sector bit zero refuses writes
// - lock zero refuses persistent bit changes
// - persistent mode: lock set at reset only
// - password mode: lock set by match
// - mode bits select lock management
// - programming mode bits to 00 fails
// - selected mode refuses further mode programming
// - mode programming busy shown by write-in-progress
// - fresh device: persistent, all sectors unprotected
// - locked persistent bit command fails unchanged
// - software reset leaves lock bit alone
// - password mismatch: fail flag, busy stays, lock kept
// - unlock attempts spaced by password gap
//
// Implementation choices: the address map and strobed register access.
module fwp_guard
  import fwp_pkg::*;
#(
  parameter int PWD_GAP = PWD_GAP_CYCLES,
  parameter int PROG_TIME = PROG_CYCLES,
  parameter int ERASE_TIME = ERASE_CYCLES
) (
  // clock and power-on reset
  input wire logic clock_in,
  input wire logic srst_in,
  // pins from the outside world
  input wire logic hw_reset_n_in,
  input wire logic write_protect_n_in,
  input wire logic spi_clk_in,
  // decoded commands from the framing logic, toggle marks a new one
  input wire logic cmd_toggle_in,
  input wire fwp_cmd_t cmd_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // status
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic program_fail_out,
  output logic guard_lock_out,
  output logic freeze_out,
  // permission to the array core
  output logic array_go_out,
  output fwp_array_req_t array_req_out
);

  localparam int GAP_W = $clog2(PWD_GAP + 1);
  localparam int BUSY_W = $clog2(ERASE_TIME + PROG_TIME + 1);

  typedef enum {ST_IDLE, ST_BUSY, ST_FAILED} fwp_state_t;

  // synchronisers: first stage feeds only the second
  logic sclk_s1, sclk_s2, sclk_s3;
  logic tog_s1, tog_s2, tog_seen;
  logic wp_n_s1, wp_n_s2;
  logic hwr_n_s1, hwr_n_s2;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      wp_n_s1 <= 1'b1;
      wp_n_s2 <= 1'b1;
      hwr_n_s1 <= 1'b1;
      hwr_n_s2 <= 1'b1;
    end else begin
      sclk_s1 <= spi_clk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      tog_s1 <= cmd_toggle_in;
      tog_s2 <= tog_s1;
      wp_n_s1 <= write_protect_n_in;
      wp_n_s2 <= wp_n_s1;
      hwr_n_s1 <= hw_reset_n_in;
      hwr_n_s2 <= hwr_n_s1;
    end
  end

  // framing updates the toggle away from the rising link edge, so sample there
  logic cmd_take;
  logic hw_rst;
  assign cmd_take = (tog_s2 != tog_seen) && sclk_s2 && !sclk_s3;
  assign hw_rst = !hwr_n_s2;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      tog_seen <= 1'b0;
    end else if (cmd_take) begin
      tog_seen <= tog_s2;
    end
  end

  // state
  fwp_state_t state;
  logic [BUSY_W-1:0] busy_cnt;
  logic [GAP_W-1:0] gap_cnt;
  logic write_enable_latch;
  logic fail_flag;
  logic [2:0] size_bits;
  logic from_bottom;
  logic freeze;
  logic status_lock;
  logic guard_lock;
  logic [7:0] mode_reg;
  logic [63:0] password;
  logic [NUM_SECTORS-1:0] psb;
  logic [NUM_SECTORS-1:0] vsb;
  logic [SECTOR_BITS-1:0] sect_sel;

  logic [1:0] mode_sel;
  logic pwd_mode;
  assign mode_sel = mode_reg[MODE_SEL_LSB +: 2];
  assign pwd_mode = (mode_sel == MODE_PASSWORD);

  // per-sector combined protection
  logic [SECTOR_BITS:0] guard_cnt;
  logic [NUM_SECTORS-1:0] sect_prot;

  always_comb begin
    if (size_bits == SIZE_NONE) begin
      guard_cnt = '0;
    end else if (size_bits == SIZE_ALL) begin
      guard_cnt = (SECTOR_BITS+1)'(NUM_SECTORS);
    end else begin
      guard_cnt = (SECTOR_BITS+1)'(NUM_SECTORS >> (3'h7 - size_bits));
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SECTORS; gi++) begin : g_sect
      logic blk_hit;
      assign blk_hit = from_bottom ? ((SECTOR_BITS+1)'(gi) < guard_cnt)
                                   : ((SECTOR_BITS+1)'(gi) >= (SECTOR_BITS+1)'(NUM_SECTORS) - guard_cnt);
      assign sect_prot[gi] = blk_hit | !psb[gi] | !vsb[gi];
    end
  endgenerate

  // command decode
  logic idle_take;
  fwp_op_t op;
  logic needs_wel;
  logic start_ok;
  logic start_fail;
  logic pwd_match;
  logic regs_blocked;
  logic [BUSY_W-1:0] op_time;

  assign idle_take = cmd_take && (state == ST_IDLE);
  assign op = cmd_in.op;
  assign pwd_match = (cmd_in.data == password);
  assign regs_blocked = !wp_n_s2 && status_lock;

  always_comb begin
    needs_wel = 1'b1;
    start_fail = 1'b0;
    op_time = BUSY_W'(PROG_TIME);
    case (op)
      CMD_PAGE_WRITE, CMD_QUAD_PAGE_WRITE: begin
        start_fail = sect_prot[cmd_in.sector];
      end
      CMD_REGION_WIPE: begin
        start_fail = sect_prot[cmd_in.sector];
        op_time = BUSY_W'(ERASE_TIME);
      end
      CMD_CHIP_WIPE: begin
        start_fail = |sect_prot;
        op_time = BUSY_W'(ERASE_TIME);
      end
      CMD_OTP_BYTE_WRITE: begin
        start_fail = freeze;
      end
      CMD_PSB_PROGRAM, CMD_PSB_ERASE: begin
        start_fail = !guard_lock;
      end
      CMD_MODE_PROGRAM: begin
        start_fail = (mode_sel != MODE_UNSELECTED)
                     || (cmd_in.data[MODE_SEL_LSB +: 2] == MODE_ILLEGAL);
      end
      CMD_PASSWORD_PROGRAM: begin
        start_fail = pwd_mode;
      end
      CMD_PASSWORD_UNLOCK: begin
        needs_wel = 1'b0;
        start_fail = !pwd_match;
        op_time = BUSY_W'(1);
      end
      CMD_WRITE_REGS, CMD_VSB_WRITE, CMD_GUARD_LOCK_CLEAR: begin
        start_fail = 1'b0;
      end
      default: begin
        needs_wel = 1'b0;
        op_time = '0;
      end
    endcase
  end

  logic timed_op;
  assign timed_op = (op_time != '0);
  // without the latch a modifying command is simply dropped
  assign start_ok = idle_take && timed_op && (write_enable_latch || !needs_wel) && !start_fail;
  logic start_bad;
  assign start_bad = idle_take && timed_op && (write_enable_latch || !needs_wel) && start_fail;

  logic clear_ok;
  assign clear_ok = cmd_take && (op == CMD_CLEAR_STATUS) && (state == ST_FAILED) && (gap_cnt == '0);

  // busy sequencer
  always_ff @(posedge clock_in) begin
    if (srst_in || hw_rst) begin
      state <= ST_IDLE;
      busy_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            state <= ST_BUSY;
            busy_cnt <= op_time - BUSY_W'(1);
          end else if (start_bad) begin
            state <= ST_FAILED;
          end
        end
        ST_BUSY: begin
          if (busy_cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            busy_cnt <= busy_cnt - BUSY_W'(1);
          end
        end
        ST_FAILED: begin
          if (clear_ok) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // spacing of failed password attempts
  always_ff @(posedge clock_in) begin
    if (srst_in || hw_rst) begin
      gap_cnt <= '0;
    end else if (start_bad && (op == CMD_PASSWORD_UNLOCK)) begin
      gap_cnt <= GAP_W'(PWD_GAP);
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - GAP_W'(1);
    end
  end

  // write enable latch
  always_ff @(posedge clock_in) begin
    if (srst_in || hw_rst) begin
      write_enable_latch <= 1'b0;
    end else if (idle_take && (op == CMD_WRITE_ENABLE)) begin
      write_enable_latch <= 1'b1;
    end else if (idle_take && ((op == CMD_WRITE_DISABLE) || (op == CMD_SOFT_RESET))) begin
      write_enable_latch <= 1'b0;
    end else if ((state == ST_BUSY) && (busy_cnt == '0)) begin
      write_enable_latch <= 1'b0;
    end else if (clear_ok) begin
      write_enable_latch <= 1'b0;
    end
  end

  // program fail flag: a new failure beats a clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (srst_in || hw_rst) begin
      fail_flag <= 1'b0;
    end else if (start_bad) begin
      fail_flag <= 1'b1;
    end else if (clear_ok) begin
      fail_flag <= 1'b0;
    end
  end

  // block protection and freeze
  logic wrr_take;
  assign wrr_take = start_ok && (op == CMD_WRITE_REGS) && !regs_blocked;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      size_bits <= SIZE_NONE;
      from_bottom <= 1'b0;
      status_lock <= 1'b0;
      freeze <= 1'b0;
    end else if (wrr_take) begin
      status_lock <= cmd_in.data[ST_LOCK_BIT];
      freeze <= freeze | cmd_in.data[CFG_DATA_LSB + CFG_FREEZE_BIT];
      if (!freeze) begin
        size_bits <= cmd_in.data[ST_SIZE_LSB +: 3];
        from_bottom <= cmd_in.data[CFG_DATA_LSB + CFG_BOTTOM_BIT];
      end // frozen fields just keep their value, no error
    end
  end

  // sector bits: persistent ones survive every reset but power-on
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      psb <= '1;
    end else if (start_ok && (op == CMD_PSB_PROGRAM)) begin
      psb[cmd_in.sector] <= 1'b0;
    end else if (start_ok && (op == CMD_PSB_ERASE)) begin
      psb <= '1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || hw_rst || (idle_take && (op == CMD_SOFT_RESET))) begin
      vsb <= '1;
    end else if (start_ok && (op == CMD_VSB_WRITE)) begin
      vsb[cmd_in.sector] <= cmd_in.data[0];
    end
  end

  // lock bit, untouched by software reset
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      guard_lock <= 1'b1;
    end else if (hw_rst) begin
      guard_lock <= !pwd_mode;
    end else if (start_ok && (op == CMD_GUARD_LOCK_CLEAR)) begin
      guard_lock <= 1'b0;
    end else if (start_ok && (op == CMD_PASSWORD_UNLOCK) && pwd_mode) begin
      guard_lock <= 1'b1;
    end
  end

  // one-time mode selection and hidden password
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      mode_reg <= MODE_REG_RESET;
    end else if (start_ok && (op == CMD_MODE_PROGRAM)) begin
      mode_reg <= mode_reg & cmd_in.data[7:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      password <= PASSWORD_RESET;
    end else if (start_ok && (op == CMD_PASSWORD_PROGRAM)) begin
      password <= password & cmd_in.data; // only ones can become zeros
    end
  end

  // array permission to the core
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      array_go_out <= 1'b0;
      array_req_out <= '0;
    end else begin
      array_go_out <= start_ok && ((op == CMD_PAGE_WRITE) || (op == CMD_QUAD_PAGE_WRITE)
                      || (op == CMD_REGION_WIPE) || (op == CMD_CHIP_WIPE) || (op == CMD_OTP_BYTE_WRITE));
      if (start_ok) begin
        array_req_out.op <= op;
        array_req_out.sector <= cmd_in.sector;
      end
    end
  end

  // register port
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sect_sel <= '0;
    end else if (reg_wr_in && (reg_addr_in == REG_SECT_SEL)) begin
      sect_sel <= reg_wdata_in[SECTOR_BITS-1:0];
    end
  end

  logic [7:0] status_byte;
  always_comb begin
    status_byte = '0;
    status_byte[ST_WIP_BIT] = (state != ST_IDLE);
    status_byte[ST_WEL_BIT] = write_enable_latch;
    status_byte[ST_SIZE_LSB +: 3] = size_bits;
    status_byte[ST_FAIL_BIT] = fail_flag;
    status_byte[ST_LOCK_BIT] = status_lock;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: reg_rdata_out <= status_byte;
        REG_CONFIG: reg_rdata_out <= {2'h0, from_bottom, 4'h0, freeze};
        REG_LOCK: reg_rdata_out <= {7'h0, guard_lock};
        REG_MODE: reg_rdata_out <= mode_reg;
        REG_SECT_SEL: reg_rdata_out <= sect_sel;
        REG_SECT_STATE: reg_rdata_out <= {5'h0, sect_prot[sect_sel], vsb[sect_sel], psb[sect_sel]};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  assign write_in_progress_out = status_byte[ST_WIP_BIT];
  assign write_enable_latch_out = write_enable_latch;
  assign program_fail_out = fail_flag;
  assign guard_lock_out = guard_lock;
  assign freeze_out = freeze;

endmodule

/* test/fwp_guard_sva.sv */
// concurrent checks on the protection block's status and permission outputs
module fwp_guard_sva #(
  parameter int PROG_TIME = 64
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // watched outputs
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic program_fail_out,
  input wire logic guard_lock_out,
  input wire logic freeze_out,
  input wire logic array_go_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  int busy_len;
  logic timed;
  // length of the current busy stretch, and whether it started an array op
  always_ff @(posedge clock_in) begin
    if (srst_in || !write_in_progress_out) begin
      busy_len <= 0;
      timed <= 1'b0;
    end else begin
      busy_len <= busy_len + 1;
      if (array_go_out) timed <= 1'b1;
    end
  end
  a_reset_values: assert property ($past(srst_in) |-> !write_enable_latch_out &&
    !program_fail_out && guard_lock_out && !freeze_out) else $error("state after reset wrong");
  a_freeze_sticky: assert property (freeze_out |=> freeze_out)
    else $error("freeze dropped without power-on reset");
  a_go_needs_wel: assert property (array_go_out |-> write_enable_latch_out &&
    $past(write_enable_latch_out)) else $error("array op started without latch");
  a_go_busy: assert property (array_go_out |-> write_in_progress_out && !program_fail_out)
    else $error("array op started but not busy");
  a_fail_busy: assert property (program_fail_out |-> write_in_progress_out)
    else $error("fail flag without busy");
  a_fail_no_go: assert property ($rose(program_fail_out) |-> !array_go_out ##1 program_fail_out)
    else $error("failed op reached the array");
  a_wel_done: assert property ($fell(write_in_progress_out) |-> !write_enable_latch_out)
    else $error("latch still set after completion");
  a_busy_span: assert property ($fell(write_in_progress_out) && timed |-> busy_len >= PROG_TIME - 1)
    else $error("array op busy too short");
endmodule

bind fwp_guard fwp_guard_sva #(.PROG_TIME(PROG_TIME)) i_sva (
  .clock_in(clock_in),
  .srst_in(srst_in),
  .write_in_progress_out(write_in_progress_out),
  .write_enable_latch_out(write_enable_latch_out),
  .program_fail_out(program_fail_out),
  .guard_lock_out(guard_lock_out),
  .freeze_out(freeze_out),
  .array_go_out(array_go_out)
);

/* test/fwp_host.sv */
// host model: one command per frame, link clock runs only inside frames
module fwp_host
  import fwp_pkg::*;
(
  // clock and request from the bench
  input wire logic clock_in,
  input wire logic send_in,
  input wire fwp_cmd_t cmd_in,
  // link towards the block
  output logic spi_clk_out,
  output logic toggle_out,
  output fwp_cmd_t cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 80;
  initial begin
    toggle_out = 1'b0;
    cmd_out = '0;
  end
  // 40 system cycles per link period, two periods per frame
  assign spi_clk_out = (cnt < 80) && (((cnt / 20) % 2) == 1);
  always @(posedge clock_in) begin
    if (send_in) begin
      cmd_out <= cmd_in;
      toggle_out <= ~toggle_out;
      cnt <= 0;
    end else if (cnt < 80) begin
      cnt <= cnt + 1;
      // payload is stale after the frame, so do not leave it looking valid
      if (cnt == 79) cmd_out.data <= ~cmd_out.data;
    end
  end
endmodule

/* test/fwp_guard_tb.sv */
// self-checking bench for the write-protection block
module fwp_guard_tb;
  import fwp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic hw_n = 1'b1;
  logic wp_n = 1'b1;
  logic send = 1'b0;
  fwp_cmd_t hcmd = '0;
  logic spi, tgl, write_in_progress, write_enable_latch, fail, lock, frz, go;
  fwp_cmd_t cmd;
  fwp_array_req_t req;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  int bad_count = 0;
  int samples_checked = 0;
  int gos = 0;
  fwp_op_t ops[8] = '{CMD_PAGE_WRITE, CMD_QUAD_PAGE_WRITE, CMD_REGION_WIPE, CMD_CHIP_WIPE,
    CMD_WRITE_DISABLE, CMD_WRITE_REGS, CMD_OTP_BYTE_WRITE, CMD_SOFT_RESET};

  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) if (go) gos <= gos + 1;

  fwp_host i_host (.clock_in(clock_in), .send_in(send), .cmd_in(hcmd), .spi_clk_out(spi),
    .toggle_out(tgl), .cmd_out(cmd));
  // gap longer than one frame, so an early clear after a bad password is refused
  fwp_guard #(.PWD_GAP(200), .PROG_TIME(4), .ERASE_TIME(8)) i_dut (
    .clock_in(clock_in), .srst_in(srst_in), .hw_reset_n_in(hw_n), .write_protect_n_in(wp_n),
    .spi_clk_in(spi), .cmd_toggle_in(tgl), .cmd_in(cmd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .write_in_progress_out(write_in_progress),
    .write_enable_latch_out(write_enable_latch), .program_fail_out(fail), .guard_lock_out(lock),
    .freeze_out(frz), .array_go_out(go), .array_req_out(req));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one frame, then wait until the block is idle or has failed
  task automatic run(input fwp_op_t op, input logic [7:0] sec = 8'h00, input logic [63:0] d = '0);
    @(posedge clock_in);
    hcmd <= '{op, sec, d};
    send <= 1'b1;
    @(posedge clock_in);
    send <= 1'b0;
    cyc(90);
    for (int i = 0; i < 400 && write_in_progress && !fail; i++) cyc(1);
  endtask
  task automatic wen();
    run(CMD_WRITE_ENABLE);
  endtask
  task automatic write_regs_cmd(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1;
    chk(nm, rdata & m, e);
  endtask
  task automatic wregs(input logic [15:0] d);
    wen();
    run(CMD_WRITE_REGS, 8'h00, {48'h0, d});
  endtask
  task automatic tryw(input logic [7:0] sec, input logic ef);
    wen();
    run(CMD_PAGE_WRITE, sec);
    chk("write fail", 8'(fail), 8'(ef));
    if (!ef) chk("req sector", req.sector, sec);
    if (fail) run(CMD_CLEAR_STATUS);
  endtask
  task automatic hwr();
    @(posedge clock_in);
    hw_n <= 1'b0;
    cyc(10);
    hw_n <= 1'b1;
    cyc(10);
  endtask

  initial begin
    int n, p;
    cyc(20);
    srst_in <= 1'b0;
    cyc(2);
    rchk("status", REG_STATUS, 8'h7f, 8'h00);
    rchk("mode", REG_MODE, 8'hff, 8'hff);
    rchk("sector", REG_SECT_STATE, 8'h07, 8'h03);
    chk("lock", 8'(lock), 8'h01);
    n = gos;
    run(CMD_PAGE_WRITE, 8'h10);
    chk("dropped", 8'(gos - n), 8'h00);
    foreach (ops[i]) begin
      wen();
      chk("wel set", 8'(write_enable_latch), 8'h01);
      run(ops[i]);
      chk("wel clear", 8'(write_enable_latch), 8'h00);
    end
    // one scheme at a time throughout, block guard first
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 8; s++) begin
        n = (s == 0) ? 0 : 256 >> (7 - s);
        wregs(16'((b << 13) | (s << 2)));
        rchk("size", REG_STATUS, 8'h1c, 8'(s << 2));
        p = b ? n - 1 : 256 - n;
        if (n > 0) tryw(8'(p), 1'b1);
        p = b ? n : 255 - n;
        if (n < 256) tryw(8'(p), 1'b0);
      end
    end
    wregs(16'h0000);
    write_regs_cmd(REG_SECT_SEL, 8'h05);
    wen();
    run(CMD_VSB_WRITE, 8'h05, 64'h0);
    rchk("vbit", REG_SECT_STATE, 8'h07, 8'h05);
    tryw(8'h05, 1'b1);
    wen();
    run(CMD_VSB_WRITE, 8'h05, 64'h1);
    tryw(8'h05, 1'b0);
    write_regs_cmd(REG_SECT_SEL, 8'h09);
    wen();
    run(CMD_PSB_PROGRAM, 8'h09);
    rchk("pbit", REG_SECT_STATE, 8'h07, 8'h06);
    tryw(8'h09, 1'b1);
    wen();
    run(CMD_GUARD_LOCK_CLEAR);
    chk("lock clr", 8'(lock), 8'h00);
    wen();
    run(CMD_PSB_ERASE, 8'h09);
    chk("erase fail", 8'(fail), 8'h01);
    rchk("pbit kept", REG_SECT_STATE, 8'h07, 8'h06);
    run(CMD_CLEAR_STATUS);
    run(CMD_SOFT_RESET);
    chk("lock soft", 8'(lock), 8'h00);
    hwr();
    chk("lock hw", 8'(lock), 8'h01);
    wen();
    run(CMD_PSB_ERASE, 8'h09);
    tryw(8'h09, 1'b0);
    wregs(16'h0088);
    wp_n <= 1'b0;
    wregs(16'h0000);
    rchk("pin lock", REG_STATUS, 8'h1c, 8'h08);
    wp_n <= 1'b1;
    wregs(16'h0000);
    rchk("pin free", REG_STATUS, 8'h1c, 8'h00);
    wregs(16'h0104);
    chk("freeze", 8'(frz), 8'h01);
    wregs(16'h201c);
    rchk("frozen", REG_STATUS, 8'h1c, 8'h04);
    rchk("frz cfg", REG_CONFIG, 8'h21, 8'h01);
    chk("no err", 8'(fail), 8'h00);
    wen();
    run(CMD_OTP_BYTE_WRITE);
    chk("otp", 8'(fail), 8'h01);
    run(CMD_CLEAR_STATUS);
    hwr();
    chk("frz hw", 8'(frz), 8'h01);
    wen();
    run(CMD_MODE_PROGRAM, 8'h00, 64'hf9);
    chk("mode 00", 8'(fail), 8'h01);
    rchk("mode", REG_MODE, 8'hff, 8'hff);
    run(CMD_CLEAR_STATUS);
    wen();
    run(CMD_PASSWORD_PROGRAM, 8'h00, PW);
    wen();
    run(CMD_MODE_PROGRAM, 8'h00, 64'hfb);
    rchk("mode pw", REG_MODE, 8'hff, 8'hfb);
    wen();
    run(CMD_MODE_PROGRAM, 8'h00, 64'hfd);
    chk("mode again", 8'(fail), 8'h01);
    rchk("mode kept", REG_MODE, 8'hff, 8'hfb);
    run(CMD_CLEAR_STATUS);
    hwr();
    chk("pw lock", 8'(lock), 8'h00);
    run(CMD_PASSWORD_UNLOCK, 8'h00, ~PW);
    chk("bad pw busy", 8'(write_in_progress), 8'h01);
    chk("bad pw fail", 8'(fail), 8'h01);
    chk("bad pw lock", 8'(lock), 8'h00);
    run(CMD_CLEAR_STATUS);
    chk("gap hold", 8'(fail), 8'h01);
    cyc(200);
    run(CMD_CLEAR_STATUS);
    chk("gap over", 8'(fail), 8'h00);
    run(CMD_PASSWORD_UNLOCK, 8'h00, PW);
    chk("pw ok", 8'(lock), 8'h01);
    srst_in <= 1'b1;
    cyc(2);
    srst_in <= 1'b0;
    cyc(2);
    chk("frz por", 8'(frz), 8'h00);
    rchk("mode por", REG_MODE, 8'hff, 8'hff);
    conclude();
  end

  // whole sequence needs roughly 16k cycles
  initial begin
    cyc(60000);
    bad_count++;
    conclude();
  end
endmodule
